// ---- aasp_map.vh ----
// aasp_map.vh - port addresses, sequence lengths and field positions
// assumes an 8-bit legacy i/o port bus with one-cycle read and write strobes
// Contract
// - master controller port reads step through twelve saved control words
// - counter-0 port reads give status, base counts over seven steps
// - counter-2 port read gives low six status bits of counter 2
// - rtc index port read gives nmi enable and last index
// - controller readback forces reserved bits to fixed values
// - alternate-mode writes to dma status ports load read-only status
// - normal-mode base writes also load current address or count
// - leaving alternate mode after timer reads leaves faster tick period
`ifndef AASP_MAP_VH
`define AASP_MAP_VH
`define AASP_ADDR_DMA_STS_LO   8'h08
`define AASP_ADDR_INT_MASTER   8'h20
`define AASP_ADDR_TMR_CNT0     8'h40
`define AASP_ADDR_TMR_CNT2     8'h42
`define AASP_ADDR_RTC_INDEX    8'h70
`define AASP_ADDR_DMA_STS_HI   8'hd0
`define AASP_INT_SEQ_LEN       4'hc
`define AASP_TMR_SEQ_LEN       3'h7
`define AASP_TMR_STS_W         6
`define AASP_RTC_NMI_BIT       7
`define AASP_OPW3_PATTERN      2'h1
`define AASP_FAST_TICK_US      13500
`define AASP_NORMAL_TICK_US    54600
`endif

// ---- aasp_seq_counter.v ----
// aasp_seq_counter.v - wrapping read-step counter for one port
// assumes clear and step come from logic on the same clock
`timescale 1ns/1ps
module aasp_seq_counter #(
  parameter WIDTH = 4,
  parameter LAST  = 11
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             arst_n_in,
  // control
  input  wire             clear_in,
  input  wire             step_in,
  // state
  output reg  [WIDTH-1:0] count_out
);
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_out <= {WIDTH{1'b0}};
    end else if (clear_in) begin
      // a read on the entry edge already counts as the first step
      count_out <= step_in ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
    end else if (step_in) begin
      if (count_out == LAST[WIDTH-1:0]) begin
        count_out <= {WIDTH{1'b0}};
      end else begin
        count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // aasp_seq_counter

// ---- aasp_shadow_ports.v ----
// aasp_shadow_ports.v - alternate access read and write paths for legacy ports
// assumes the legacy units present their saved words as inputs and take
// dma loads and a fast-tick flag as outputs; all inputs on clk_in
`timescale 1ns/1ps
`include "aasp_map.vh"
module aasp_shadow_ports (
  // clock and reset
  input  wire        clk_in,
  input  wire        arst_n_in,
  // mode
  input  wire        alternate_access_in,
  // host i/o port access
  input  wire [7:0]  io_addr_in,
  input  wire [7:0]  io_wdata_in,
  input  wire        io_rd_in,
  input  wire        io_wr_in,
  output reg  [7:0]  io_rdata_out,
  output reg         io_rvalid_out,
  // interrupt controller saved words, master then slave
  input  wire [7:0]  m_init_word_second_in,
  input  wire [7:0]  m_init_word_third_in,
  input  wire [7:0]  m_init_word_fourth_in,
  input  wire [7:0]  m_operation_word_first_in,
  input  wire [7:0]  m_operation_word_second_in,
  input  wire [7:0]  m_operation_word_third_in,
  input  wire [7:0]  s_init_word_second_in,
  input  wire [7:0]  s_init_word_third_in,
  input  wire [7:0]  s_init_word_fourth_in,
  input  wire [7:0]  s_operation_word_first_in,
  input  wire [7:0]  s_operation_word_second_in,
  input  wire [7:0]  s_operation_word_third_in,
  // timer state
  input  wire [5:0]  tmr0_status_in,
  input  wire [15:0] tmr0_base_count_in,
  input  wire [5:0]  tmr2_status_in,
  input  wire [15:0] tmr2_base_count_in,
  output reg         tmr_fast_tick_out,
  // rtc index and nmi
  input  wire        nmi_enable_in,
  input  wire [6:0]  rtc_index_in,
  // dma status restore and base/current mirror
  output reg  [7:0]  dma_status_lo_out,
  output reg         dma_status_lo_load_out,
  output reg  [7:0]  dma_status_hi_out,
  output reg         dma_status_hi_load_out,
  input  wire        dma_base_wr_in,
  output wire        dma_current_wr_out
);
  // session tracking and port decode
  reg        alt_q;
  reg        tmr_read_q;
  wire       alt_rise;
  wire       alt_fall;
  wire       rd_alt;
  wire       wr_alt;
  wire       wr_norm;
  wire       sel_int;
  wire       sel_tmr0;
  wire       sel_tmr2;
  wire       sel_dma_lo;
  wire       sel_dma_hi;
  wire       rd_int;
  wire       rd_tmr0;
  wire       rd_tmr_any;
  // read step counters and the index the mux uses
  wire [3:0] int_step;
  wire [2:0] tmr_step;
  wire [3:0] int_idx;
  wire [2:0] tmr_idx;
  // saved words with reserved bits forced
  wire [7:0] m_iw2_fix;
  wire [7:0] m_iw4_fix;
  wire [7:0] m_ow2_fix;
  wire [7:0] m_ow3_fix;
  wire [7:0] s_iw2_fix;
  wire [7:0] s_iw4_fix;
  wire [7:0] s_ow2_fix;
  wire [7:0] s_ow3_fix;
  reg  [7:0] rdata_d;

  assign alt_rise   = alternate_access_in & ~alt_q;
  assign alt_fall   = ~alternate_access_in & alt_q;
  assign rd_alt     = io_rd_in & alternate_access_in;
  assign wr_alt     = io_wr_in & alternate_access_in;
  assign wr_norm    = io_wr_in & ~alternate_access_in;

  assign sel_int    = (io_addr_in == `AASP_ADDR_INT_MASTER);
  assign sel_tmr0   = (io_addr_in == `AASP_ADDR_TMR_CNT0);
  assign sel_tmr2   = (io_addr_in == `AASP_ADDR_TMR_CNT2);
  assign sel_dma_lo = (io_addr_in == `AASP_ADDR_DMA_STS_LO);
  assign sel_dma_hi = (io_addr_in == `AASP_ADDR_DMA_STS_HI);

  assign rd_int     = rd_alt & sel_int;
  assign rd_tmr0    = rd_alt & sel_tmr0;
  assign rd_tmr_any = rd_alt & (sel_tmr0 | sel_tmr2);

  aasp_seq_counter #(.WIDTH(4), .LAST(`AASP_INT_SEQ_LEN - 1)) u_int_seq (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .clear_in  (alt_rise),
    .step_in   (rd_int),
    .count_out (int_step)
  );
  aasp_seq_counter #(.WIDTH(3), .LAST(`AASP_TMR_SEQ_LEN - 1)) u_tmr_seq (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .clear_in  (alt_rise),
    .step_in   (rd_tmr0),
    .count_out (tmr_step)
  );
  // a read on the entry edge already sees step 0
  assign int_idx    = alt_rise ? 4'h0 : int_step;
  assign tmr_idx    = alt_rise ? 3'h0 : tmr_step;

  // reserved bits forced on readback
  function [7:0] fix_iw2;
    input [7:0] v;
    fix_iw2 = {v[7:3], 3'h0};
  endfunction
  function [7:0] fix_iw4;
    input [7:0] v;
    fix_iw4 = {3'h0, v[4], 2'h0, v[1], 1'b0};
  endfunction
  function [7:0] fix_ow2;
    input [7:0] v;
    fix_ow2 = {v[7:5], 2'h0, v[2:0]};
  endfunction
  function [7:0] fix_ow3;
    input [7:0] v;
    fix_ow3 = {1'b0, v[6], v[6], `AASP_OPW3_PATTERN, v[2:0]};
  endfunction

  assign m_iw2_fix = fix_iw2(m_init_word_second_in);
  assign m_iw4_fix = fix_iw4(m_init_word_fourth_in);
  assign m_ow2_fix = fix_ow2(m_operation_word_second_in);
  assign m_ow3_fix = fix_ow3(m_operation_word_third_in);
  assign s_iw2_fix = fix_iw2(s_init_word_second_in);
  assign s_iw4_fix = fix_iw4(s_init_word_fourth_in);
  assign s_ow2_fix = fix_ow2(s_operation_word_second_in);
  assign s_ow3_fix = fix_ow3(s_operation_word_third_in);

  always @* begin
    rdata_d = 8'h00;
    case (io_addr_in)
      `AASP_ADDR_INT_MASTER: begin
        case (int_idx)
          4'h0:    rdata_d = m_iw2_fix;
          4'h1:    rdata_d = m_init_word_third_in;
          4'h2:    rdata_d = m_iw4_fix;
          4'h3:    rdata_d = m_operation_word_first_in;
          4'h4:    rdata_d = m_ow2_fix;
          4'h5:    rdata_d = m_ow3_fix;
          4'h6:    rdata_d = s_iw2_fix;
          4'h7:    rdata_d = s_init_word_third_in;
          4'h8:    rdata_d = s_iw4_fix;
          4'h9:    rdata_d = s_operation_word_first_in;
          4'ha:    rdata_d = s_ow2_fix;
          4'hb:    rdata_d = s_ow3_fix;
          default: rdata_d = 8'h00;
        endcase
      end
      `AASP_ADDR_TMR_CNT0: begin
        case (tmr_idx)
          3'h0:    rdata_d = {2'h0, tmr0_status_in};
          3'h1:    rdata_d = tmr0_base_count_in[7:0];
          3'h2:    rdata_d = tmr0_base_count_in[15:8];
          3'h5:    rdata_d = tmr2_base_count_in[7:0];
          3'h6:    rdata_d = tmr2_base_count_in[15:8];
          default: rdata_d = 8'h00;
        endcase
      end
      `AASP_ADDR_TMR_CNT2: rdata_d = {2'h0, tmr2_status_in};
      `AASP_ADDR_RTC_INDEX: rdata_d = {nmi_enable_in, rtc_index_in};
      default: rdata_d = 8'h00;
    endcase
  end

  // session state: entry edge and timer reads seen
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alt_q      <= 1'b0;
      tmr_read_q <= 1'b0;
    end else begin
      alt_q      <= alternate_access_in;
      // a timer read on the entry edge still counts for this session
      tmr_read_q <= (tmr_read_q & ~alt_rise) | rd_tmr_any;
    end
  end

  // read answer, one cycle after the strobe
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io_rvalid_out <= 1'b0;
      io_rdata_out  <= 8'h00;
    end else begin
      io_rvalid_out <= rd_alt;
      if (rd_alt) begin
        io_rdata_out <= rdata_d;
      end
    end
  end

  // fast tick after exit from a session with timer reads, until the timer is reprogrammed
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmr_fast_tick_out <= 1'b0;
    end else if (alt_fall & tmr_read_q) begin
      tmr_fast_tick_out <= 1'b1;
    end else if (wr_norm & (sel_tmr0 | sel_tmr2)) begin
      // reprogramming restores the normal period
      tmr_fast_tick_out <= 1'b0;
    end
  end

  // low channel status restore, alternate mode only
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_status_lo_out      <= 8'h00;
      dma_status_lo_load_out <= 1'b0;
    end else begin
      dma_status_lo_load_out <= wr_alt & sel_dma_lo;
      if (wr_alt & sel_dma_lo) begin
        dma_status_lo_out <= io_wdata_in;
      end
    end
  end

  // high channel status restore, alternate mode only
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_status_hi_out      <= 8'h00;
      dma_status_hi_load_out <= 1'b0;
    end else begin
      dma_status_hi_load_out <= wr_alt & sel_dma_hi;
      if (wr_alt & sel_dma_hi) begin
        dma_status_hi_out <= io_wdata_in;
      end
    end
  end

  // base writes mirror to current only outside alternate mode
  assign dma_current_wr_out = dma_base_wr_in & ~alternate_access_in;
endmodule // aasp_shadow_ports

// ---- aasp_shadow_ports_chk.sv ----
// aasp_shadow_ports_chk.sv - port-level checks of the shadow port block
// assumes a bind to aasp_shadow_ports on its single clock
`timescale 1ns/1ps
module aasp_chk (
  input wire logic       clk_in, arst_n_in, alternate_access_in, io_rd_in, io_wr_in,
  input wire logic       io_rvalid_out, dma_status_lo_load_out, dma_status_hi_load_out,
  input wire logic       dma_base_wr_in, dma_current_wr_out, nmi_enable_in, tmr_fast_tick_out,
  input wire logic [7:0] io_addr_in, io_wdata_in, io_rdata_out, dma_status_lo_out,
  input wire logic [6:0] rtc_index_in,
  input wire logic [5:0] tmr2_status_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire rd_alt = io_rd_in && alternate_access_in;
  wire wr_alt = io_wr_in && alternate_access_in;
  AST_RVALID: assert property (rd_alt |=> io_rvalid_out)
    else $error("alternate read not answered");
  AST_NO_RVALID: assert property (!rd_alt |=> !io_rvalid_out)
    else $error("read answered without an alternate read");
  AST_RTC_READ: assert property (rd_alt && io_addr_in == 8'h70 |=>
    io_rdata_out == {$past(nmi_enable_in), $past(rtc_index_in)}) else $error("rtc readback");
  AST_TMR2_READ: assert property (rd_alt && io_addr_in == 8'h42 |=>
    io_rdata_out == {2'h0, $past(tmr2_status_in)}) else $error("counter 2 status readback");
  AST_LO_LOAD: assert property (wr_alt && io_addr_in == 8'h08 |=> dma_status_lo_load_out &&
    dma_status_lo_out == $past(io_wdata_in)) else $error("low status restore");
  AST_HI_LOAD: assert property (wr_alt && io_addr_in == 8'hd0 |=> dma_status_hi_load_out)
    else $error("high status restore");
  AST_NO_LOAD: assert property (io_wr_in && !alternate_access_in |=>
    !dma_status_lo_load_out && !dma_status_hi_load_out) else $error("status load in normal mode");
  AST_CURRENT: assert property (dma_current_wr_out == (dma_base_wr_in && !alternate_access_in))
    else $error("current register mirror");
  AST_FAST_CLR: assert property (io_wr_in && !alternate_access_in && !$past(alternate_access_in) &&
    io_addr_in == 8'h40 |=> !tmr_fast_tick_out) else $error("fast tick not cleared");
endmodule // aasp_chk
bind aasp_shadow_ports aasp_chk aasp_chk_inst (.*);

// ---- aasp_legacy_model.sv ----
// aasp_legacy_model.sv - legacy unit stand-in with saved words
// assumes it sits beside the block and takes its restore loads
`timescale 1ns/1ps
module aasp_legacy_model (
  // clock, reset and restore loads
  input  wire logic        clk_in, arst_n_in, dma_status_lo_load_out, dma_status_hi_load_out,
  input  wire logic [7:0]  dma_status_lo_out, dma_status_hi_out,
  output logic      [15:0] dma_status_q,
  // saved words and timer state
  output wire logic [7:0]  m_init_word_second_in, m_init_word_third_in, m_init_word_fourth_in,
  output wire logic [7:0]  m_operation_word_first_in, m_operation_word_second_in,
  output wire logic [7:0]  m_operation_word_third_in, s_init_word_second_in, s_init_word_third_in,
  output wire logic [7:0]  s_init_word_fourth_in, s_operation_word_first_in,
  output wire logic [7:0]  s_operation_word_second_in, s_operation_word_third_in,
  output wire logic [5:0]  tmr0_status_in, tmr2_status_in,
  output wire logic [15:0] tmr0_base_count_in, tmr2_base_count_in,
  output wire logic        nmi_enable_in,
  output wire logic [6:0]  rtc_index_in
);
  assign {m_init_word_second_in, m_init_word_third_in, m_init_word_fourth_in,
    m_operation_word_first_in, m_operation_word_second_in, m_operation_word_third_in} = 48'ha53cffc3ffbf;
  assign {s_init_word_second_in, s_init_word_third_in, s_init_word_fourth_in,
    s_operation_word_first_in, s_operation_word_second_in, s_operation_word_third_in} = 48'h5f02027e1840;
  assign {tmr0_status_in, tmr0_base_count_in} = 22'h2abeef;
  assign {tmr2_status_in, tmr2_base_count_in} = 22'h151234;
  assign {nmi_enable_in, rtc_index_in} = 8'hca;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_status_q <= 16'h0000;
    end else begin
      if (dma_status_lo_load_out) dma_status_q[7:0] <= dma_status_lo_out;
      if (dma_status_hi_load_out) dma_status_q[15:8] <= dma_status_hi_out;
    end
  end
endmodule // aasp_legacy_model

// ---- tb_alternate_access_shadow_ports.sv ----
// tb_alternate_access_shadow_ports.sv - directed port access tests
// assumes the legacy model feeds saved words and the checker is bound
`timescale 1ns/1ps
module tb_alternate_access_shadow_ports;
  logic clk_in = 1'b0, arst_n_in = 1'b0, alternate_access_in = 1'b0, dma_base_wr_in = 1'b0;
  logic io_rd_in = 1'b0, io_wr_in = 1'b0;
  logic [7:0] io_addr_in = 8'h00, io_wdata_in = 8'h00;
  wire [7:0] io_rdata_out, dma_status_lo_out, dma_status_hi_out, m_init_word_second_in,
    m_init_word_third_in, m_init_word_fourth_in, m_operation_word_first_in, m_operation_word_second_in,
    m_operation_word_third_in, s_init_word_second_in, s_init_word_third_in, s_init_word_fourth_in,
    s_operation_word_first_in, s_operation_word_second_in, s_operation_word_third_in;
  wire io_rvalid_out, tmr_fast_tick_out, dma_status_lo_load_out, dma_status_hi_load_out,
    dma_current_wr_out, nmi_enable_in;
  wire [5:0] tmr0_status_in, tmr2_status_in;
  wire [15:0] tmr0_base_count_in, tmr2_base_count_in, dma_status_q;
  wire [6:0] rtc_index_in;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  logic [7:0] pic_exp [12] = '{8'ha0, 8'h3c, 8'h12, 8'hc3, 8'he7, 8'h0f,
    8'h58, 8'h02, 8'h02, 8'h7e, 8'h00, 8'h68};
  logic [7:0] tmr_exp [7] = '{8'h2a, 8'hef, 8'hbe, 8'h00, 8'h00, 8'h34, 8'h12};
  aasp_shadow_ports aasp_shadow_ports_inst (.*);
  aasp_legacy_model aasp_legacy_model_inst (.*);
  initial forever #12.5 clk_in = ~clk_in;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic io_rd(input logic [7:0] a, input logic [7:0] exp, input logic v);
    @(negedge clk_in) io_addr_in = a;
    io_rd_in = 1'b1;
    @(negedge clk_in) io_rd_in = 1'b0;
    check("rvalid", io_rvalid_out, v);
    if (v) check("rdata", io_rdata_out, exp);
  endtask
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in) io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(negedge clk_in) io_wr_in = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(negedge clk_in);
    arst_n_in = 1'b1;
    io_rd(8'h70, 8'h00, 1'b0);
    io_wr(8'h08, 8'h11);
    @(negedge clk_in) check("status no load", dma_status_q, 16'h0000);
    @(negedge clk_in) dma_base_wr_in = 1'b1;
    #1 check("current mirror", dma_current_wr_out, 1'b1);
    @(negedge clk_in) alternate_access_in = 1'b1;
    #1 check("current in alt", dma_current_wr_out, 1'b0);
    @(negedge clk_in) dma_base_wr_in = 1'b0;
    $display("test refusal and mirror done");
    for (int i = 0; i < 13; i++) io_rd(8'h20, pic_exp[i % 12], 1'b1);
    for (int i = 0; i < 7; i++) io_rd(8'h40, tmr_exp[i], 1'b1);
    io_rd(8'h42, 8'h15, 1'b1);
    io_rd(8'h70, 8'hca, 1'b1);
    $display("test read paths done");
    io_wr(8'h08, 8'h5a);
    io_wr(8'hd0, 8'hc3);
    @(negedge clk_in) check("status restore", dma_status_q, 16'hc35a);
    check("fast tick early", tmr_fast_tick_out, 1'b0);
    $display("test write paths done");
    @(negedge clk_in) alternate_access_in = 1'b0;
    @(negedge clk_in) check("fast tick", tmr_fast_tick_out, 1'b1);
    alternate_access_in = 1'b1;
    io_rd(8'h20, 8'ha0, 1'b1);
    @(negedge clk_in) alternate_access_in = 1'b0;
    io_wr(8'h40, 8'h9c);
    @(negedge clk_in) check("fast tick clear", tmr_fast_tick_out, 1'b0);
    $display("test timer side effect done");
    final_report();
  end
endmodule // tb_alternate_access_shadow_ports
